// file: usb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
    import usb_tx_pkg::*;
(
    input  wire logic     i_core_clk,
    input  wire logic     i_rstn,
    input  wire logic     i_slow,
    input  wire tx_beat_t i_tx,
    output logic          o_in_token,
    output logic          o_sof,
    output logic          o_sof_frame_lsb,
    output logic          o_phy_ready
);
    logic [7:0] got[$];
    logic       eop_seen;
    logic       stuff_seen;
    logic       toggle;
    initial begin
        o_in_token = 1'b0;
        o_sof = 1'b0;
        o_sof_frame_lsb = 1'b0;
        toggle = 1'b0;
        eop_seen = 1'b0;
        stuff_seen = 1'b0;
    end
    // Sink stalls every other cycle when slow
    assign o_phy_ready = !i_slow || toggle;
    always @(posedge i_core_clk) begin
        toggle <= !toggle;
        if (!i_rstn) begin
            eop_seen <= 1'b0;
        end else if (i_tx.valid && o_phy_ready) begin
            if (i_tx.eop) begin
                eop_seen <= 1'b1;
                stuff_seen <= i_tx.stuff_err;
            end else begin
                got.push_back(i_tx.data);
            end
        end
    end
    task in_token();
        @(posedge i_core_clk);
        o_in_token <= 1'b1;
        @(posedge i_core_clk);
        o_in_token <= 1'b0;
    endtask : in_token
    task sof(input logic lsb);
        @(posedge i_core_clk);
        o_sof <= 1'b1;
        o_sof_frame_lsb <= lsb;
        @(posedge i_core_clk);
        o_sof <= 1'b0;
    endtask : sof
endmodule : usb_host_model
`default_nettype wire

// file: usb_tx_endpoint_control.sv
`timescale 1ns/1ps
`default_nettype none
module usb_tx_endpoint_control
    import usb_tx_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_rstn,
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic              i_read,
    input  wire logic              i_write,
    input  wire logic [DATA_W-1:0] i_writedata,
    input  wire logic [3:0]        i_byteenable,
    output logic      [DATA_W-1:0] o_readdata,
    output logic                   o_waitrequest,
    input  wire logic              i_in_token,
    input  wire logic              i_sof,
    input  wire logic              i_sof_frame_lsb,
    input  wire logic              i_phy_ready,
    output tx_beat_t               o_tx,
    output logic                   o_stall,
    output logic                   o_nak,
    output logic                   o_pkt_done
);

    //--------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------
    logic             ack;
    ctrl_t            ctrl;
    logic             iso;
    logic             stall_cfg;
    logic             frame_lsb;
    logic             warn_flag;
    logic [7:0]       fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [PTR_W-1:0] saved_rp;
    logic [PTR_W-1:0] count;
    logic [15:0]      crc;
    tx_state_t        state;
    logic             free;
    logic             busy;
    logic             eligible;
    logic             ctrl_wr;
    logic             cfg_wr;
    logic             fifo_wr;
    logic             warn_rd;
    logic             pop;
    logic             pkt_end;
    logic             underrun_end;
    logic             stall_hit;
    logic             purge_do;
    logic             refill_do;
    logic             sof_drop;
    logic             warn_set;
    logic [7:0]       pid;

    function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY_R) : (r >> 1);
        end
        return r;
    endfunction : crc_next

    //--------------------------------------------------------------
    // Avalon slave
    //--------------------------------------------------------------
    assign o_waitrequest = (i_read | i_write) & ~ack;
    assign ctrl_wr = i_write & ack & i_byteenable[0] & (i_address == CTRL_ADDR);
    assign cfg_wr  = i_write & ack & i_byteenable[0] & (i_address == CFG_ADDR);
    assign fifo_wr = i_write & ack & i_byteenable[0] & (i_address == FIFO_ADDR)
                   & (count != FULL_CNT);
    assign warn_rd = i_read & ~ack & (i_address == EVENT_ADDR);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack <= 1'b0;
        end else begin
            ack <= (i_read | i_write) & ~ack;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_readdata <= '0;
        end else if (i_read & ~ack) begin
            unique case (i_address)
                CTRL_ADDR:  o_readdata <= {24'h0, ctrl};
                CFG_ADDR:   o_readdata <= {30'h0, stall_cfg, iso};
                EVENT_ADDR: o_readdata <= {31'h0, warn_flag};
                STAT_ADDR:  o_readdata <= {17'h0, busy, rp, count};
                default:    o_readdata <= '0;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Status terms
    //--------------------------------------------------------------
    assign count = wp - rp;
    assign free  = ~o_tx.valid | i_phy_ready;
    assign busy  = (state != S_IDLE) | o_tx.valid;
    assign eligible = ctrl.tx_arm & ~ctrl.fifo_purge
                    & (~iso | ctrl.skip_frame_match | (frame_lsb == ctrl.tx_data_pid_select));
    assign pop          = (state == S_DATA) & free & (count != EMPTY_CNT);
    assign pkt_end      = (state == S_EOP) & free;
    assign underrun_end = (state == S_DATA) & free & (count == EMPTY_CNT)
                        & ~ctrl.packet_complete_mark;
    assign stall_hit    = (state == S_IDLE) & i_in_token & stall_cfg;
    assign purge_do     = ctrl.fifo_purge & ~busy;
    assign refill_do    = ctrl.refill_fifo & ~busy & ~ctrl.fifo_purge;
    assign sof_drop     = i_sof & iso & ctrl.tx_arm & ~ctrl.skip_frame_match
                        & (frame_lsb == ctrl.tx_data_pid_select) & (state == S_IDLE);
    assign pid = (~iso & ctrl.tx_data_pid_select) ? PID_DATA1 : PID_DATA0;

    //--------------------------------------------------------------
    // Control register
    //--------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl <= ctrl_t'(CTRL_RESET);
        end else if (ctrl_wr) begin
            ctrl <= ctrl_t'(i_writedata[7:0]);
        end else begin
            if (pkt_end | underrun_end | stall_hit | sof_drop | purge_do) begin
                ctrl.tx_arm <= 1'b0;
            end
            if (pkt_end | sof_drop | purge_do) begin
                ctrl.packet_complete_mark <= 1'b0;
            end
            if (purge_do) begin
                ctrl.fifo_purge <= 1'b0;
            end
            if (refill_do) begin
                ctrl.refill_fifo <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            iso       <= 1'b0;
            stall_cfg <= 1'b0;
        end else if (cfg_wr) begin
            iso       <= i_writedata[0];
            stall_cfg <= i_writedata[1];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            frame_lsb <= 1'b0;
        end else if (i_sof) begin
            frame_lsb <= i_sof_frame_lsb;
        end
    end

    //--------------------------------------------------------------
    // FIFO storage and pointers
    //--------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (fifo_wr) begin
            fifo_mem[wp[IDX_W-1:0]] <= i_writedata[7:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wp <= PTR_ZERO;
        end else if (purge_do | sof_drop) begin
            wp <= PTR_ZERO;
        end else if (fifo_wr) begin
            wp <= wp + PTR_ONE;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rp <= PTR_ZERO;
        end else if (purge_do | sof_drop) begin
            rp <= PTR_ZERO;
        end else if (refill_do) begin
            rp <= saved_rp;
        end else if (pop) begin
            rp <= rp + PTR_ONE;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            saved_rp <= PTR_ZERO;
        end else if (ctrl_wr & i_writedata[1]) begin
            saved_rp <= rp;
        end
    end

    //--------------------------------------------------------------
    // Warning event
    //--------------------------------------------------------------
    // Threshold check
    assign warn_set = ctrl.tx_arm
        & (((ctrl.tx_fifo_warn_limit == WARN_LT5) & (count < WARN_CNT5))
        | ((ctrl.tx_fifo_warn_limit == WARN_LT17) & (count < WARN_CNT17)));

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            warn_flag <= 1'b0;
        end else if (warn_set) begin
            warn_flag <= 1'b1;
        end else if (warn_rd) begin
            warn_flag <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // Transmit state machine
    //--------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state      <= S_IDLE;
            o_tx       <= '0;
            crc        <= CRC_INIT;
            o_stall    <= 1'b0;
            o_nak      <= 1'b0;
            o_pkt_done <= 1'b0;
        end else begin
            o_stall    <= 1'b0;
            o_nak      <= 1'b0;
            o_pkt_done <= 1'b0;
            if (i_phy_ready) begin
                o_tx.valid <= 1'b0;
            end
            unique case (state)
                S_IDLE: begin
                    if (i_in_token) begin
                        if (stall_cfg) begin
                            o_stall <= 1'b1;
                        end else if (eligible) begin
                            state <= S_PID;
                        end else if (!iso) begin
                            o_nak <= 1'b1;
                        end
                    end
                end
                S_PID: begin
                    if (free) begin
                        o_tx  <= '{valid: 1'b1, eop: 1'b0, stuff_err: 1'b0, data: pid};
                        crc   <= CRC_INIT;
                        state <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (free) begin
                        if (count != EMPTY_CNT) begin
                            o_tx <= '{valid: 1'b1, eop: 1'b0, stuff_err: 1'b0,
                                      data: fifo_mem[rp[IDX_W-1:0]]};
                            crc  <= crc_next(crc, fifo_mem[rp[IDX_W-1:0]]);
                        end else if (ctrl.packet_complete_mark) begin
                            o_tx  <= '{valid: 1'b1, eop: 1'b0, stuff_err: 1'b0,
                                       data: ~crc[7:0]};
                            state <= S_CRC_HI;
                        end else begin
                            o_tx       <= '{valid: 1'b1, eop: 1'b1, stuff_err: 1'b1,
                                            data: 8'h00};
                            state      <= S_IDLE;
                            o_pkt_done <= 1'b1;
                        end
                    end
                end
                S_CRC_HI: begin
                    if (free) begin
                        o_tx  <= '{valid: 1'b1, eop: 1'b0, stuff_err: 1'b0,
                                   data: ~crc[15:8]};
                        state <= S_EOP;
                    end
                end
                S_EOP: begin
                    if (free) begin
                        o_tx       <= '{valid: 1'b1, eop: 1'b1, stuff_err: 1'b0,
                                        data: 8'h00};
                        state      <= S_IDLE;
                        o_pkt_done <= 1'b1;
                    end
                end
            endcase
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    property p_iso_pid;
        (state == S_PID) && free && iso |=> o_tx.valid && (o_tx.data == PID_DATA0);
    endproperty
    a_iso_pid: assert property (p_iso_pid) else $error("iso pid not DATA0");

    property p_pid_sel;
        (state == S_PID) && free && !iso
            |=> o_tx.data == ($past(ctrl.tx_data_pid_select) ? PID_DATA1 : PID_DATA0);
    endproperty
    a_pid_sel: assert property (p_pid_sel) else $error("wrong data pid");

    property p_frame_block;
        (state == S_IDLE) && i_in_token && iso && !ctrl.skip_frame_match
            && (frame_lsb != ctrl.tx_data_pid_select) |=> (state == S_IDLE) && !o_nak;
    endproperty
    a_frame_block: assert property (p_frame_block) else $error("sent off frame");

    property p_skip;
        (state == S_IDLE) && i_in_token && iso && ctrl.skip_frame_match && ctrl.tx_arm
            && !ctrl.fifo_purge && !stall_cfg |=> state == S_PID;
    endproperty
    a_skip: assert property (p_skip) else $error("skip ignored");

    property p_warn_arm;
        $rose(warn_flag) |-> $past(ctrl.tx_arm) && ($past(ctrl.tx_fifo_warn_limit) != 2'h3);
    endproperty
    a_warn_arm: assert property (p_warn_arm) else $error("warn unarmed");

    property p_warn_lt5;
        ctrl.tx_arm && (ctrl.tx_fifo_warn_limit == WARN_LT5) && (count < WARN_CNT5)
            |=> warn_flag;
    endproperty
    a_warn_lt5: assert property (p_warn_lt5) else $error("warn missed");

    property p_purge;
        ctrl.fifo_purge && !busy |=> (wp == PTR_ZERO) && (rp == PTR_ZERO);
    endproperty
    a_purge: assert property (p_purge) else $error("purge failed");

    property p_purge_defer;
        ctrl.fifo_purge && busy && !ctrl_wr |=> ctrl.fifo_purge;
    endproperty
    a_purge_defer: assert property (p_purge_defer) else $error("purge early");

    property p_refill;
        refill_do && !ctrl_wr && !sof_drop |=> (rp == $past(saved_rp)) && !ctrl.refill_fifo;
    endproperty
    a_refill: assert property (p_refill) else $error("refill failed");

    property p_underrun;
        underrun_end |=> o_tx.stuff_err && o_tx.eop && (state == S_IDLE);
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun missed");

    property p_stall_arm;
        stall_hit && !ctrl_wr |=> o_stall && !ctrl.tx_arm;
    endproperty
    a_stall_arm: assert property (p_stall_arm) else $error("arm kept");

    c_zlp:     cover property ((state == S_DATA) && ctrl.packet_complete_mark
                               && (count == EMPTY_CNT) ##1 state == S_CRC_HI);
    c_under:   cover property (underrun_end);
    c_sofdrop: cover property (sof_drop);
    c_stall:   cover property (stall_hit);

endmodule : usb_tx_endpoint_control
`default_nettype wire

// file: usb_tx_endpoint_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module usb_tx_endpoint_control_bench;
    import usb_tx_pkg::*;
    logic              i_core_clk, i_rstn, i_read, i_write, slow;
    logic [ADDR_W-1:0] i_address;
    logic [DATA_W-1:0] i_writedata, o_readdata, q, seed;
    logic [3:0]        i_byteenable;
    logic              i_in_token, i_sof, i_sof_frame_lsb, i_phy_ready;
    logic              o_waitrequest, o_stall, o_nak, o_pkt_done;
    tx_beat_t          o_tx;
    logic [7:0]        pl[$];
    int                errors, n_compared, cyc, n_nak, n_stall, n_done;
    int                cnt[4] = '{4, 5, 16, 17};
    usb_tx_endpoint_control usb_tx_endpoint_control_i (.i_core_clk, .i_rstn, .i_address,
        .i_read, .i_write, .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest,
        .i_in_token, .i_sof, .i_sof_frame_lsb, .i_phy_ready, .o_tx, .o_stall, .o_nak,
        .o_pkt_done);
    usb_host_model usb_host_model_i (.i_core_clk, .i_rstn, .i_slow(slow), .i_tx(o_tx),
        .o_in_token(i_in_token), .o_sof(i_sof), .o_sof_frame_lsb(i_sof_frame_lsb),
        .o_phy_ready(i_phy_ready));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always #2.5 i_core_clk = !i_core_clk;
    always @(posedge i_core_clk) begin
        cyc++;
        if (o_nak === 1'b1) n_nak++;
        if (o_stall === 1'b1) n_stall++;
        if (o_pkt_done === 1'b1) n_done++;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] crc16();
        logic [15:0] c;
        c = CRC_INIT;
        foreach (pl[i]) begin
            for (int b = 0; b < 8; b++) begin
                c = (c[0] ^ pl[i][b]) ? (c >> 1) ^ CRC_POLY_R : c >> 1;
            end
        end
        return ~c;
    endfunction : crc16
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_address <= a;
        i_write <= w;
        i_read <= !w;
        i_writedata <= {24'h0, d};
        do begin @(posedge i_core_clk); end while (o_waitrequest);
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : bus
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_pkt(input logic [7:0] pid, input logic stuff);
        logic [7:0]  e[$];
        logic [15:0] c;
        c = crc16();
        e = {pid, pl};
        if (!stuff) e = {e, c[7:0], c[15:8]};
        while (!usb_host_model_i.eop_seen) @(posedge i_core_clk);
        repeat (2) @(posedge i_core_clk);
        chk_word(n_done, 32'h1);
        chk_word({31'h0, usb_host_model_i.stuff_seen}, {31'h0, stuff});
        chk_word(usb_host_model_i.got.size(), e.size());
        foreach (e[i]) chk_word({24'h0, usb_host_model_i.got[i]}, {24'h0, e[i]});
    endtask : chk_pkt
    task automatic load(input int n);
        logic [31:0] r;
        pl.delete();
        repeat (n) begin r = rnd(); pl.push_back(r[7:0]); bus(1'b1, FIFO_ADDR, r[7:0]); end
    endtask : load
    task automatic go();
        usb_host_model_i.got.delete();
        usb_host_model_i.eop_seen = 1'b0;
        n_done = 0;
        usb_host_model_i.in_token();
    endtask : go
    task automatic poll(input logic [7:0] m);
        int k;
        k = 0;
        do begin bus(1'b0, CTRL_ADDR, 8'h0); k++; end while ((q[7:0] & m) != 8'h0 && k < 50);
        chk_word(q & {24'h0, m}, 32'h0);
    endtask : poll
    task automatic test_done();
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        int e;
        i_core_clk = 0; i_rstn = 0; i_read = 0; i_write = 0; slow = 0; i_address = '0;
        i_writedata = '0; i_byteenable = 4'h1; seed = 32'd16998;
        repeat (10) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        bus(1'b0, CTRL_ADDR, 8'h0); chk_word(q, {24'h0, CTRL_RESET});
        bus(1'b0, CTRL_ADDR + 34'h40, 8'h0); chk_word(q, 32'h0);
        i_byteenable <= 4'he;
        bus(1'b1, CTRL_ADDR, 8'h04);
        i_byteenable <= 4'h1;
        bus(1'b0, CTRL_ADDR, 8'h0); chk_word(q, 32'h0);
        for (int k = 0; k < 4; k++) begin
            slow <= k[0];
            load(k == 3 ? 0 : 1 + rnd() % 8);
            bus(1'b1, CTRL_ADDR, {5'h0, k[0], 2'h3});
            go(); chk_pkt(k[0] ? PID_DATA1 : PID_DATA0, 1'b0);
            bus(1'b0, CTRL_ADDR, 8'h0); chk_word(q & 32'h3, 32'h0);
        end
        load(4); bus(1'b1, CTRL_ADDR, 8'h03); go(); chk_pkt(PID_DATA0, 1'b0);
        bus(1'b1, CTRL_ADDR, 8'h10); poll(8'h10);
        bus(1'b1, CTRL_ADDR, 8'h03); go(); chk_pkt(PID_DATA0, 1'b0);
        load(2); bus(1'b1, CTRL_ADDR, 8'h01); go(); chk_pkt(PID_DATA0, 1'b1);
        slow <= 1'b1; load(6); bus(1'b1, CTRL_ADDR, 8'h01); go();
        bus(1'b1, CTRL_ADDR, 8'h0b); chk_pkt(PID_DATA0, 1'b0);
        poll(8'h08); bus(1'b0, STAT_ADDR, 8'h0); chk_word(q & 32'h3fff, 32'h0);
        for (int k = 0; k < 16; k++) begin
            bus(1'b0, EVENT_ADDR, 8'h0);
            load(cnt[k % 4]);
            bus(1'b1, CTRL_ADDR, {1'b0, k[3:2], 5'h00}); repeat (3) @(posedge i_core_clk);
            bus(1'b0, EVENT_ADDR, 8'h0); chk_word(q & 32'h1, 32'h0);
            bus(1'b1, CTRL_ADDR, {1'b0, k[3:2], 5'h01}); repeat (3) @(posedge i_core_clk);
            e = (k[3:2] == 2'h1 && cnt[k % 4] < 5) || (k[3:2] == 2'h2 && cnt[k % 4] < 17);
            bus(1'b0, EVENT_ADDR, 8'h0); chk_word(q & 32'h1, e);
            bus(1'b1, CTRL_ADDR, 8'h08); poll(8'h08);
        end
        slow <= 1'b0; n_nak = 0; bus(1'b1, CFG_ADDR, 8'h01); usb_host_model_i.sof(1'b0);
        load(3); bus(1'b1, CTRL_ADDR, 8'h07); go(); repeat (30) @(posedge i_core_clk);
        chk_word(usb_host_model_i.got.size() + n_nak, 32'h0);
        usb_host_model_i.sof(1'b1); go(); chk_pkt(PID_DATA0, 1'b0);
        load(3); bus(1'b1, CTRL_ADDR, 8'h07); usb_host_model_i.sof(1'b0);
        bus(1'b0, STAT_ADDR, 8'h0); chk_word(q & 32'h7f, 32'h0);
        bus(1'b0, CTRL_ADDR, 8'h0); chk_word(q & 32'h3, 32'h0);
        load(3); bus(1'b1, CTRL_ADDR, 8'h87); go(); chk_pkt(PID_DATA0, 1'b0);
        n_stall = 0; bus(1'b1, CFG_ADDR, 8'h02); bus(1'b1, CTRL_ADDR, 8'h01); go();
        repeat (5) @(posedge i_core_clk); chk_word(n_stall, 32'h1);
        bus(1'b0, CTRL_ADDR, 8'h0); chk_word(q & 32'h1, 32'h0);
        bus(1'b1, CFG_ADDR, 8'h00); n_nak = 0; go();
        repeat (5) @(posedge i_core_clk); chk_word(n_nak, 32'h1);
        test_done();
    end
endmodule : usb_tx_endpoint_control_bench
`default_nettype wire

// file: usb_tx_pkg.sv
`default_nettype none
package usb_tx_pkg;
    localparam int ADDR_W = 34;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 64;
    localparam int PTR_W = 7;
    localparam int IDX_W = 6;

    // Register index and byte addresses
    localparam logic [ADDR_W-1:0] CTRL_IDX   = 34'h050001866;
    localparam logic [ADDR_W-1:0] CTRL_ADDR  = {CTRL_IDX[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] FIFO_ADDR  = CTRL_ADDR + 34'h4;
    localparam logic [ADDR_W-1:0] CFG_ADDR   = CTRL_ADDR + 34'h8;
    localparam logic [ADDR_W-1:0] EVENT_ADDR = CTRL_ADDR + 34'hc;
    localparam logic [ADDR_W-1:0] STAT_ADDR  = CTRL_ADDR + 34'h10;

    localparam logic [7:0]       CTRL_RESET = 8'h00;
    localparam logic [PTR_W-1:0] FULL_CNT   = 7'h40;
    localparam logic [PTR_W-1:0] EMPTY_CNT  = 7'h00;
    localparam logic [PTR_W-1:0] PTR_ZERO   = 7'h00;
    localparam logic [PTR_W-1:0] PTR_ONE    = 7'h01;

    // Warning limit codes and thresholds
    localparam logic [1:0]       WARN_OFF   = 2'h0;
    localparam logic [1:0]       WARN_LT5   = 2'h1;
    localparam logic [1:0]       WARN_LT17  = 2'h2;
    localparam logic [PTR_W-1:0] WARN_CNT5  = 7'h05;
    localparam logic [PTR_W-1:0] WARN_CNT17 = 7'h11;

    localparam logic [7:0]  PID_DATA0  = 8'hc3;
    localparam logic [7:0]  PID_DATA1  = 8'h4b;
    localparam logic [15:0] CRC_INIT   = 16'hffff;
    localparam logic [15:0] CRC_POLY_R = 16'ha001;

    typedef struct packed {
        logic       skip_frame_match;
        logic [1:0] tx_fifo_warn_limit;
        logic       refill_fifo;
        logic       fifo_purge;
        logic       tx_data_pid_select;
        logic       packet_complete_mark;
        logic       tx_arm;
    } ctrl_t;

    typedef struct packed {
        logic       valid;
        logic       eop;
        logic       stuff_err;
        logic [7:0] data;
    } tx_beat_t;

    typedef enum logic [2:0] {S_IDLE, S_PID, S_DATA, S_CRC_HI, S_EOP} tx_state_t;
endpackage : usb_tx_pkg
`default_nettype wire
